/* File: sar_adc_ctrl.sv */
// Conversion timing, busy, track/hold and power-down control with serial readout
// Notes on behaviour
// - Convert-start fall: hold and begin converting
// - Conversion clock comes from internal oscillator
// - 3.8us high-rate, 9.8us from wake edge
// - Result in output register 3.8us after fall
// - Bipolar variants give two's complement result
// - Unipolar variant gives straight binary result
// - Busy fall returns track/hold to tracking
// - Auto-sleep: hold 6us after wake edge
// - Read is sixteen serial clock pulses
// - After sixteenth pulse reset shifter, release output
// - Extra pulses keep advancing the shifter
// - Convert-start fall resets shifter and counter; here only while the serial clock is low
// - Four zeros then twelve bits MSB first
// - Busy rises on fall, drops at completion
// - Start still low at end: power down
`default_nettype none
module sar_adc_ctrl
  import sar_pkg::*;
#(
  parameter bit BIPOLAR = 1'b1
)
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_convert_start_n,
  input wire logic i_sclk,
  input wire logic i_cmp,
  output logic o_busy,
  output logic o_hold,
  output logic o_sleep,
  output logic [RES_BITS-1:0] o_dac_code,
  output logic o_serial_result_out,
  output logic o_serial_result_out_oe
);
  logic [2:0] cs_sync_q;
  logic cs_fall;
  logic cs_rise;
  conv_state_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [3:0] bit_idx_q;
  logic [RES_BITS-1:0] sar_q;
  logic [RES_BITS-1:0] result_q;
  logic frame_rst_n;

  // i_clk stands for the internal oscillator
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cs_sync_q <= SYNC_RST;
    end else begin
      cs_sync_q <= {cs_sync_q[1:0], i_convert_start_n};
    end
  end

  assign cs_fall = cs_sync_q[2] & ~cs_sync_q[1];
  assign cs_rise = ~cs_sync_q[2] & cs_sync_q[1];

  // Main sequencer
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_TRACK;
      cnt_q <= CNT_ZERO;
    end else begin
      case (state_q)
        ST_TRACK: begin
          if (cs_fall) begin
            state_q <= ST_CONV;
            cnt_q <= CNT_ZERO;
          end
        end
        ST_CONV: begin
          if (cnt_q == CNT_W'(CONV_CYCLES - 1)) begin
            // Busy falls here; low start means power down
            state_q <= cs_sync_q[1] ? ST_TRACK : ST_SLEEP;
            cnt_q <= CNT_ZERO;
          end else begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        ST_SLEEP: begin
          if (cs_rise) begin
            state_q <= ST_WAKE;
            cnt_q <= CNT_ZERO;
          end
        end
        ST_WAKE: begin
          // Hold comes at the later of wake-up done and start fall
          if (cnt_q >= CNT_W'(WAKE_CYCLES - 1) && !cs_sync_q[1]) begin
            state_q <= ST_CONV;
            cnt_q <= CNT_ZERO;
          end else if (cnt_q < CNT_W'(WAKE_CYCLES - 1)) begin
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        default: begin
          state_q <= ST_TRACK;
          cnt_q <= CNT_ZERO;
        end
      endcase
    end
  end

  // Busy follows the start fall through completion, also across wake-up from sleep
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_busy <= 1'b0;
    end else if (cs_fall) begin
      o_busy <= 1'b1;
    end else if (state_q == ST_CONV && cnt_q == CNT_W'(CONV_CYCLES - 1)) begin
      o_busy <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hold <= 1'b0;
      o_sleep <= 1'b0;
    end else begin
      o_hold <= (state_q == ST_TRACK && cs_fall) || (state_q == ST_CONV &&
                 cnt_q != CNT_W'(CONV_CYCLES - 1)) ||
                (state_q == ST_WAKE && cnt_q >= CNT_W'(WAKE_CYCLES - 1) && !cs_sync_q[1]);
      o_sleep <= (state_q == ST_SLEEP && !cs_rise) ||
                 (state_q == ST_CONV && cnt_q == CNT_W'(CONV_CYCLES - 1) && !cs_sync_q[1]);
    end
  end

  // Successive approximation, one bit per slice of the conversion window
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bit_idx_q <= 4'hB;
      sar_q <= RESULT_RST;
    end else if (state_q != ST_CONV) begin
      bit_idx_q <= 4'hB;
      sar_q <= MSB_FLIP;
    end else if (cnt_q[5:0] == 6'h3F && cnt_q[CNT_W-1:6] <= 7'h0B) begin
      // Twelve trials of 64 cycles each finish well inside the conversion window
      sar_q[bit_idx_q] <= i_cmp;
      if (bit_idx_q != 4'h0) begin
        sar_q[bit_idx_q - 4'h1] <= 1'b1;
        bit_idx_q <= bit_idx_q - 4'h1;
      end
    end
  end

  assign o_dac_code = sar_q;

  // Output register loaded at completion, coded by range variant
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      result_q <= RESULT_RST;
    end else if (state_q == ST_CONV && cnt_q == CNT_W'(CONV_CYCLES - 1)) begin
      result_q <= BIPOLAR ? (sar_q ^ MSB_FLIP) : sar_q;
    end
  end

  // Frame reset is the raw start pin low, qualified by serial clock low
  assign frame_rst_n = i_convert_start_n | i_sclk;

  sar_serial_out u_serial (
    .i_sclk(i_sclk),
    .i_frame_rst_n(frame_rst_n),
    .i_result(result_q),
    .o_serial_result_out(o_serial_result_out),
    .o_serial_result_out_oe(o_serial_result_out_oe)
  );
endmodule
`default_nettype wire

/* File: sar_pkg.sv */
// Constants and types shared by the converter control and its serial readout
`default_nettype none
package sar_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned RES_BITS = 12;
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned LEAD_ZEROS = 4;
  // Times in nanoseconds as printed
  localparam int unsigned CONV_TIME_NS = 3800;
  localparam int unsigned WAKE_TIME_NS = 6000;
  // Longest times round down
  localparam int unsigned CONV_CYCLES = CONV_TIME_NS * CLK_MHZ / 1000;
  localparam int unsigned WAKE_CYCLES = WAKE_TIME_NS * CLK_MHZ / 1000;
  localparam int unsigned CNT_W = 13;
  localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;
  localparam logic [4:0] BIT_CNT_RST = 5'h00;
  localparam logic [FRAME_BITS-1:0] SHIFT_RST = 16'h0000;
  localparam logic [2:0] SYNC_RST = 3'h7;
  localparam logic [RES_BITS-1:0] RESULT_RST = 12'h000;
  // Bipolar result: offset sample flipped to two's complement
  localparam logic [RES_BITS-1:0] MSB_FLIP = 12'h800;

  typedef enum logic [1:0] {
    ST_TRACK = 2'b00,
    ST_CONV = 2'b01,
    ST_SLEEP = 2'b10,
    ST_WAKE = 2'b11
  } conv_state_e;
endpackage
`default_nettype wire

/* File: sar_serial_out.sv */
// Serial result shifter running on the controller's serial clock
`default_nettype none
module sar_serial_out
  import sar_pkg::*;
(
  input wire logic i_sclk,
  input wire logic i_frame_rst_n,
  input wire logic [RES_BITS-1:0] i_result,
  output logic o_serial_result_out,
  output logic o_serial_result_out_oe
);
  logic [4:0] bit_cnt_q;
  logic [FRAME_BITS-1:0] word;

  // Result is stable whenever the serial clock runs outside conversion
  assign word = {{LEAD_ZEROS{1'b0}}, i_result};

  // Counter cleared asynchronously while convert-start and serial clock are both low
  always_ff @(negedge i_sclk or negedge i_frame_rst_n) begin
    if (!i_frame_rst_n) begin
      bit_cnt_q <= BIT_CNT_RST;
    end else begin
      // Counts on past sixteen and wraps from 31 back to zero
      bit_cnt_q <= (bit_cnt_q == 5'h0F) ? 5'h10 : ((bit_cnt_q == 5'h1F) ? 5'h00 : bit_cnt_q + 5'h01);
    end
  end

  // Bit shifts on falling edges, MSB of frame first
  always_ff @(negedge i_sclk or negedge i_frame_rst_n) begin
    if (!i_frame_rst_n) begin
      o_serial_result_out <= 1'b0;
      o_serial_result_out_oe <= 1'b1;
    end else begin
      o_serial_result_out <= (bit_cnt_q[3:0] == 4'hF) ? 1'b0 : word[4'hE - bit_cnt_q[3:0]];
      // Released after the sixteenth edge, driven again by extra pulses
      o_serial_result_out_oe <= (bit_cnt_q != 5'h0F);
    end
  end
endmodule
`default_nettype wire

/* File: sar_checker.sv */
// Port assertions for the converter control
`default_nettype none
module sar_checker
  import sar_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_convert_start_n,
  input wire logic i_sclk,
  input wire logic o_busy,
  input wire logic o_hold,
  input wire logic o_sleep,
  input wire logic o_serial_result_out,
  input wire logic o_serial_result_out_oe
);
  logic [10:0] busy_q;
  logic [10:0] rise_q;
  logic wake_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Hold length, time since start rose, and a wake from sleep in progress
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_q <= 11'h000;
      rise_q <= 11'h000;
      wake_q <= 1'b0;
    end else begin
      busy_q <= o_hold ? busy_q + 11'h001 : 11'h000;
      rise_q <= $rose(i_convert_start_n) ? 11'h000 : rise_q + 11'h001;
      wake_q <= (wake_q || (o_sleep && $rose(i_convert_start_n))) && !o_hold;
    end
  end
  a_busy_start: assert property (
    $fell(i_convert_start_n) && !o_busy && !o_sleep && !wake_q |-> ##[1:5] o_busy) else $error("busy late");
  a_conv_time: assert property (
    $fell(o_busy) |-> busy_q >= CONV_CYCLES - 2 && busy_q <= CONV_CYCLES + 1) else $error("conversion length");
  a_hold_conv: assert property (o_busy && !wake_q |-> o_hold) else $error("not held");
  a_track_end: assert property ($fell(o_busy) |-> ##[0:1] !o_hold) else $error("no tracking");
  a_sleep_low: assert property (
    $fell(o_busy) && !i_convert_start_n |-> ##[0:4] o_sleep) else $error("no sleep");
  a_wake_early: assert property (
    wake_q && rise_q < WAKE_CYCLES - 4 |-> !o_hold) else $error("hold before wake");
  a_wake_late: assert property (
    wake_q && !i_convert_start_n |-> rise_q <= WAKE_CYCLES + 6) else $error("hold after wake");
  a_frame_rst: assert property (
    !i_convert_start_n && !i_sclk && !$past(i_convert_start_n) && !$past(i_sclk) |-> o_serial_result_out_oe && !o_serial_result_out)
    else $error("frame not reset");
endmodule
bind sar_adc_ctrl sar_checker chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_convert_start_n(i_convert_start_n),
  .i_sclk(i_sclk), .o_busy(o_busy), .o_hold(o_hold), .o_sleep(o_sleep), .o_serial_result_out(o_serial_result_out), .o_serial_result_out_oe(o_serial_result_out_oe));
`default_nettype wire

/* File: sar_serial_master.sv */
// Serial port master that clocks a readout of n serial pulses
`default_nettype none
module sar_serial_master (
  output var logic o_sclk,
  input wire logic i_serial_result_out,
  input wire logic i_serial_result_out_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial o_sclk = 1'b0;
  // A released line shows the inverse of the design's value
  task automatic read(input int n, output logic [15:0] d, output logic oe);
    d = 16'h0000;
    repeat (n) begin
      #7.5 o_sclk = 1'b1;
      d = {d[14:0], i_serial_result_out_oe ? i_serial_result_out : !i_serial_result_out};
      #7.5 o_sclk = 1'b0;
    end
    #7.5 oe = i_serial_result_out_oe;
  endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the converter control
`default_nettype none
module testbench;
  import sar_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic st_n = 1'b1;
  logic cmp = 1'b0;
  logic [11:0] tgt = 12'h000;
  logic [11:0] dac;
  logic busy, hold, sleep, serial_result_out, oe, sclk;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  sar_adc_ctrl uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_convert_start_n(st_n), .i_sclk(sclk), .i_cmp(cmp),
    .o_busy(busy), .o_hold(hold), .o_sleep(sleep), .o_dac_code(dac), .o_serial_result_out(serial_result_out), .o_serial_result_out_oe(oe));
  sar_serial_master m (.o_sclk(sclk), .i_serial_result_out(serial_result_out), .i_serial_result_out_oe(oe));
  initial forever #2 i_clk = !i_clk;
  always @(posedge i_clk) begin
    cmp <= dac <= tgt;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wait_busy(input logic v, output int n);
    n = 0;
    while (busy !== v && n < 3000) begin
      @(posedge i_clk);
      n++;
    end
  endtask
  task automatic read_chk(input logic [11:0] e, input int k);
    logic [15:0] d;
    logic z;
    m.read(k, d, z);
    if (k == 16) chk("frame", {4'h0, e}, d);
    chk("serial_result_out_oe", {15'h0000, k != 16}, {15'h0000, z});
  endtask
  task automatic convert(input logic [11:0] t, input logic rest);
    int n;
    tgt <= t;
    @(posedge i_clk);
    st_n <= 1'b0;
    wait_busy(1'b1, n);
    repeat (8) @(posedge i_clk);
    st_n <= rest;
    wait_busy(1'b0, n);
  endtask
  task automatic s_codes();
    logic [11:0] c [4] = '{12'h123, 12'h800, 12'h7FF, 12'hFFF};
    foreach (c[i]) begin
      convert(c[i], 1'b1);
      read_chk(c[i] ^ MSB_FLIP, 16);
      repeat (80) @(posedge i_clk);
    end
  endtask
  task automatic s_extra();
    convert(12'h456, 1'b1);
    read_chk(12'hC56, 17);
    repeat (80) @(posedge i_clk);
    convert(12'h456, 1'b1);
    read_chk(12'hC56, 16);
  endtask
  task automatic s_sleep();
    int n;
    convert(12'h3A5, 1'b0);
    repeat (8) @(posedge i_clk);
    chk("sleep", 16'h0001, {15'h0000, sleep});
    st_n <= 1'b1;
    repeat (100) @(posedge i_clk);
    st_n <= 1'b0;
    n = 0;
    while (hold !== 1'b1 && n < 3000) begin
      @(posedge i_clk);
      n++;
    end
    chk("wake", 16'h0001, {15'h0000, n + 100 >= WAKE_CYCLES && n + 100 <= WAKE_CYCLES + 8});
    wait_busy(1'b0, n);
    st_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    read_chk(12'hBA5, 16);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    s_codes();
    s_extra();
    s_sleep();
    test_done();
  end
endmodule
`default_nettype wire
